/* design/dpc_defs.svh */
// Offsets, field positions, reset values and timing constants of the pulse counter front end.
`ifndef DPC_DEFS_SVH
`define DPC_DEFS_SVH

// Clock and time base.
`define DPC_CLK_NS          20
`define DPC_US_NS           1000
`define DPC_US_CYC          (`DPC_US_NS / `DPC_CLK_NS)
`define DPC_MS_US           1000
`define DPC_RATE_WIN_MS     1000

// Least stable times in microseconds, contact kind and all other kinds.
`define DPC_DEB_CON_DEF_US   1600
`define DPC_DEB_CON_HEAVY_US 3200
`define DPC_DEB_CON_LIGHT_US 400
`define DPC_DEB_OTH_DEF_US   40
`define DPC_DEB_OTH_HEAVY_US 350
`define DPC_DEB_OTH_LIGHT_US 5

// Display refresh intervals in milliseconds, codes 0 to 5.
`define DPC_DISP_MS_0       500
`define DPC_DISP_MS_1       1000
`define DPC_DISP_MS_2       2000
`define DPC_DISP_MS_3       3000
`define DPC_DISP_MS_4       4000
`define DPC_DISP_MS_5       5000

// Register byte offsets.
`define DPC_OFF_INPUT_CFG   5'h00
`define DPC_OFF_DISP_CFG    5'h04
`define DPC_OFF_TOTAL       5'h08
`define DPC_OFF_RATE        5'h0C
`define DPC_OFF_UPPER       5'h10
`define DPC_OFF_LOWER       5'h14
`define DPC_OFF_STATUS      5'h18
`define DPC_OFF_CTRL        5'h1C

// Field positions of the input configuration register.
`define DPC_F_KIND_A        0
`define DPC_F_KIND_B        3
`define DPC_F_DEB_A         6
`define DPC_F_DEB_B         8
`define DPC_F_EDGE_A        10
`define DPC_F_EDGE_B        11
`define DPC_F_MODE          12

// Field positions of the display configuration register.
`define DPC_F_INTERVAL      0
`define DPC_F_UPPER_SEL     3
`define DPC_F_LOWER_EN      4

// Reset values of the fields that are not zero.
`define DPC_RST_INTERVAL    3'h1
`define DPC_RST_LOWER_EN    1'h1

`endif

/* design/dpc_pkg.sv */
// Types shared by the pulse counter front end modules.
package dpc_pkg;

  // Sensor kinds of an input.
  typedef enum logic [2:0] {
    KIND_OPEN_COLL, KIND_VOLT_LOW, KIND_VOLT_HIGH, KIND_MAG_PICKOFF, KIND_PROXIMITY, KIND_CONTACT
  } dpc_kind_t;

  // Debounce levels; code 3 behaves as the default level.
  typedef enum logic [1:0] {DEB_DEFAULT, DEB_HEAVY, DEB_LIGHT} dpc_deb_t;

  // Arithmetic count modes.
  typedef enum logic [1:0] {MODE_SUM, MODE_DIFF, MODE_DIR, MODE_QUAD} dpc_mode_t;

  // State of one input conditioner.
  typedef struct packed {
    logic [2:0]  sh;
    logic [2:0]  sl;
    logic        hi_ok;
    logic        lo_ok;
    logic [11:0] cnt;
    logic        level;
    logic        rise;
    logic        fall;
  } dpc_cond_st_t;

  // State of the top module.
  typedef struct packed {
    logic        wreq;
    logic [31:0] rdata;
    logic [2:0]  kind_a;
    logic [2:0]  kind_b;
    logic [1:0]  deb_a;
    logic [1:0]  deb_b;
    logic        edge_a;
    logic        edge_b;
    dpc_mode_t   mode;
    logic [2:0]  interval;
    logic        upper_sel;
    logic        lower_en;
    logic [31:0] total;
    logic [31:0] rate;
    logic [31:0] rate_acc;
    logic [15:0] us_cnt;
    logic        us_tick;
    logic [9:0]  ms_cnt;
    logic        ms_tick;
    logic [9:0]  win_ms;
    logic [12:0] disp_ms;
    logic [31:0] upper;
    logic [31:0] lower;
    logic        upper_is_rate;
    logic        lower_on;
    logic        pout_ok;
  } dpc_top_st_t;

endpackage

/* design/dpc_input_cond.sv */
// One pulse input: pin synchronisers, threshold hysteresis and debounce.
`timescale 1ns/10ps
`include "dpc_defs.svh"
module dpc_input_cond (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       us_tick,
  input  wire logic       above_high,
  input  wire logic       below_low,
  input  wire logic       contact,
  input  wire logic [1:0] deb_level,
  output logic            level,
  output logic            rise,
  output logic            fall
);

  dpc_pkg::dpc_cond_st_t s_r;
  dpc_pkg::dpc_cond_st_t s_nxt;
  logic [11:0]           lim;

  // Least stable time in microseconds for the chosen kind and level.
  function automatic logic [11:0] deb_limit(input logic con, input logic [1:0] lvl);
    logic [11:0] l;
    case (lvl)
      dpc_pkg::DEB_HEAVY: l = con ? 12'(`DPC_DEB_CON_HEAVY_US) : 12'(`DPC_DEB_OTH_HEAVY_US);
      dpc_pkg::DEB_LIGHT: l = con ? 12'(`DPC_DEB_CON_LIGHT_US) : 12'(`DPC_DEB_OTH_LIGHT_US);
      default:            l = con ? 12'(`DPC_DEB_CON_DEF_US) : 12'(`DPC_DEB_OTH_DEF_US);
    endcase
    return l;
  endfunction

  assign lim = deb_limit(contact, deb_level); // [R3] [R4]

  // A level changes only after the opposite threshold was held for the whole debounce time.
  always_comb begin
    s_nxt      = s_r;
    s_nxt.sh   = {s_r.sh[1:0], above_high};
    s_nxt.sl   = {s_r.sl[1:0], below_low};
    s_nxt.rise = 1'b0;
    s_nxt.fall = 1'b0;
    if (s_r.sh[1] == s_r.sh[2]) begin
      s_nxt.hi_ok = s_r.sh[2];
    end
    if (s_r.sl[1] == s_r.sl[2]) begin
      s_nxt.lo_ok = s_r.sl[2];
    end
    // Low waits for the high threshold, high waits for the low one, so a partial swing never counts.
    if (s_r.level ? s_r.lo_ok : s_r.hi_ok) begin // [R2]
      if (s_r.cnt >= lim) begin // [R4]
        s_nxt.level = ~s_r.level;
        s_nxt.cnt   = 12'h000;
        s_nxt.rise  = ~s_r.level;
        s_nxt.fall  = s_r.level;
      end else if (us_tick) begin
        s_nxt.cnt = s_r.cnt + 12'h001;
      end
    end else begin
      s_nxt.cnt = 12'h000; // A bounce restarts the stable time.
    end
  end

  // State register with synchronous reset.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign level = s_r.level;
  assign rise  = s_r.rise;
  assign fall  = s_r.fall;

endmodule

/* design/dpc_top.sv */
// Two input pulse counter front end with Avalon-MM register access.
//
// Contract
// [R1] Second input holds one of six kinds.
// [R2] Count needs low then high threshold crossing.
// [R3] Both inputs have independent three-level debounce.
// [R4] Debounce stable times depend on contact kind.
// [R5] Edge setting picks rising or falling transitions.
// [R6] First edge setting ignored in quadrature.
// [R7] Second edge setting only for sum, difference.
// [R8] Four modes; sum adds both inputs.
// [R9] Difference: first adds, second subtracts.
// [R10] Direction mode: second level low up, high down.
// [R11] Quadrature counts up when second leads.
// [R12] Quadrature counts down when first leads.
// [R13] Quadrature tolerates unequal mark and space.
// [R14] Pulse output unavailable in flagged modes.
// [R15] Six refresh intervals, display latched only then.
// [R16] Refresh interval never slows counting or outputs.
// [R17] Upper shows total or rate, lower other.
// [R18] Lower display can be switched off.
`timescale 1ns/10ps
`include "dpc_defs.svh"
module dpc_top #(
  parameter int unsigned US_CYC = `DPC_US_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        in_a_above_high,
  input  wire logic        in_a_below_low,
  input  wire logic        in_b_above_high,
  input  wire logic        in_b_below_low,
  output logic [31:0]      disp_upper_value,
  output logic             disp_upper_is_rate,
  output logic [31:0]      disp_lower_value,
  output logic             disp_lower_on,
  output logic             pulse_out_avail
);

  dpc_pkg::dpc_top_st_t s_r;
  dpc_pkg::dpc_top_st_t s_nxt;

  logic [1:0]  hi_v;
  logic [1:0]  lo_v;
  logic [1:0]  con_v;
  logic [3:0]  deb_v;
  logic [1:0]  lvl_v;
  logic [1:0]  rise_v;
  logic [1:0]  fall_v;
  logic [31:0] wmask;
  logic [31:0] cfg_in;
  logic [31:0] cfg_disp;
  logic [31:0] stat;
  logic [31:0] rd_mux;
  logic [31:0] wr_val;
  logic [31:0] delta;
  logic [1:0]  evs;
  logic        a_ev;
  logic        b_ev;
  logic [12:0] disp_lim;

  // Channel 0 is the first input, channel 1 the second.
  assign hi_v  = {in_b_above_high, in_a_above_high};
  assign lo_v  = {in_b_below_low, in_a_below_low};
  assign con_v = {s_r.kind_b == dpc_pkg::KIND_CONTACT, s_r.kind_a == dpc_pkg::KIND_CONTACT}; // [R1]
  assign deb_v = {s_r.deb_b, s_r.deb_a};

  // One conditioner per input, each with its own kind and debounce level.
  for (genvar gi = 0; gi < 2; gi++) begin : g_in
    dpc_input_cond u_cond (
      .clk_sys    (clk_sys),
      .rst_n      (rst_n),
      .us_tick    (s_r.us_tick),
      .above_high (hi_v[gi]),
      .below_low  (lo_v[gi]),
      .contact    (con_v[gi]),
      .deb_level  (deb_v[2*gi +: 2]),
      .level      (lvl_v[gi]),
      .rise       (rise_v[gi]),
      .fall       (fall_v[gi])
    ); // [R3]
  end

  // Byte lanes that a write may change.
  for (genvar gb = 0; gb < 4; gb++) begin : g_be
    assign wmask[8*gb +: 8] = {8{avs_byteenable[gb]}};
  end

  // Readback images of the configuration and status registers.
  always_comb begin
    cfg_in                          = 32'h0000_0000;
    cfg_in[`DPC_F_KIND_A +: 3]      = s_r.kind_a;
    cfg_in[`DPC_F_KIND_B +: 3]      = s_r.kind_b;
    cfg_in[`DPC_F_DEB_A +: 2]       = s_r.deb_a;
    cfg_in[`DPC_F_DEB_B +: 2]       = s_r.deb_b;
    cfg_in[`DPC_F_EDGE_A]           = s_r.edge_a;
    cfg_in[`DPC_F_EDGE_B]           = s_r.edge_b;
    cfg_in[`DPC_F_MODE +: 2]        = s_r.mode;
    cfg_disp                        = 32'h0000_0000;
    cfg_disp[`DPC_F_INTERVAL +: 3]  = s_r.interval;
    cfg_disp[`DPC_F_UPPER_SEL]      = s_r.upper_sel;
    cfg_disp[`DPC_F_LOWER_EN]       = s_r.lower_en;
    stat                            = {28'h000_0000, s_r.lower_on, s_r.pout_ok, lvl_v};
  end

  // Read multiplexer; unmapped and write-only offsets read as zero.
  always_comb begin
    unique case (avs_address)
      `DPC_OFF_INPUT_CFG: rd_mux = cfg_in;
      `DPC_OFF_DISP_CFG:  rd_mux = cfg_disp;
      `DPC_OFF_TOTAL:     rd_mux = s_r.total;
      `DPC_OFF_RATE:      rd_mux = s_r.rate;
      `DPC_OFF_UPPER:     rd_mux = s_r.upper;
      `DPC_OFF_LOWER:     rd_mux = s_r.lower;
      `DPC_OFF_STATUS:    rd_mux = stat;
      default:            rd_mux = 32'h0000_0000;
    endcase
  end

  // Refresh interval in milliseconds; the unused codes fall back to the longest interval.
  always_comb begin
    unique case (s_r.interval)
      3'h0:    disp_lim = 13'(`DPC_DISP_MS_0);
      3'h1:    disp_lim = 13'(`DPC_DISP_MS_1);
      3'h2:    disp_lim = 13'(`DPC_DISP_MS_2);
      3'h3:    disp_lim = 13'(`DPC_DISP_MS_3);
      3'h4:    disp_lim = 13'(`DPC_DISP_MS_4);
      default: disp_lim = 13'(`DPC_DISP_MS_5);
    endcase
  end

  // Counting edges; the first input's edge setting is not consulted in quadrature.
  assign a_ev = s_r.edge_a ? fall_v[0] : rise_v[0]; // [R5] [R6]
  assign b_ev = s_r.edge_b ? fall_v[1] : rise_v[1]; // [R5] [R7]

  // Signed step of the total and the number of counted pulses for the rate.
  always_comb begin
    unique case (s_r.mode)
      dpc_pkg::MODE_SUM: begin
        delta = {31'h0000_0000, a_ev} + {31'h0000_0000, b_ev}; // [R8]
        evs   = {1'b0, a_ev} + {1'b0, b_ev};
      end
      dpc_pkg::MODE_DIFF: begin
        delta = {31'h0000_0000, a_ev} - {31'h0000_0000, b_ev}; // [R9]
        evs   = {1'b0, a_ev} + {1'b0, b_ev};
      end
      dpc_pkg::MODE_DIR: begin
        // Only the first input counts; the second input's level is the direction.
        delta = !a_ev ? 32'h0000_0000 : (lvl_v[1] ? 32'hFFFF_FFFF : 32'h0000_0001); // [R10] [R7]
        evs   = {1'b0, a_ev};
      end
      dpc_pkg::MODE_QUAD: begin
        // Decoding on the first input's rise alone keeps it insensitive to unequal mark and space.
        delta = !rise_v[0] ? 32'h0000_0000 : (lvl_v[1] ? 32'h0000_0001 : 32'hFFFF_FFFF); // [R11] [R12] [R13]
        evs   = {1'b0, rise_v[0]};
      end
    endcase
  end

  assign wr_val = (rd_mux & ~wmask) | (avs_writedata & wmask);

  // Next state: bus slave, time base, counting, rate window and display latch.
  always_comb begin
    s_nxt         = s_r;
    s_nxt.us_tick = 1'b0;
    s_nxt.ms_tick = 1'b0;

    // Waitrequest drops for one cycle after a request is seen; the access completes at the following edge.
    if ((avs_read || avs_write) && s_r.wreq) begin
      s_nxt.wreq = 1'b0;
      // Only a read loads the data register, so read data stand until the next read.
      if (avs_read) begin
        s_nxt.rdata = rd_mux;
      end
    end else begin
      s_nxt.wreq = 1'b1;
    end

    // Microsecond and millisecond ticks from the system clock.
    if (s_r.us_cnt >= 16'(US_CYC - 1)) begin
      s_nxt.us_cnt  = 16'h0000;
      s_nxt.us_tick = 1'b1;
    end else begin
      s_nxt.us_cnt = s_r.us_cnt + 16'h0001;
    end
    if (s_r.us_tick) begin
      if (s_r.ms_cnt >= 10'(`DPC_MS_US - 1)) begin
        s_nxt.ms_cnt  = 10'h000;
        s_nxt.ms_tick = 1'b1;
      end else begin
        s_nxt.ms_cnt = s_r.ms_cnt + 10'h001;
      end
    end

    // The total follows every counted pulse at once, whatever the refresh interval.
    s_nxt.total = s_r.total + delta; // [R16]

    // Rate is the pulse count of each one-second window.
    s_nxt.rate_acc = s_r.rate_acc + {30'h0000_0000, evs};
    if (s_r.ms_tick) begin
      if (s_r.win_ms >= 10'(`DPC_RATE_WIN_MS - 1)) begin
        s_nxt.win_ms   = 10'h000;
        s_nxt.rate     = s_nxt.rate_acc;
        s_nxt.rate_acc = 32'h0000_0000;
      end else begin
        s_nxt.win_ms = s_r.win_ms + 10'h001;
      end
    end

    // Display values change only when the refresh interval has run out.
    if (s_r.ms_tick) begin
      if (s_r.disp_ms >= disp_lim - 13'h0001) begin // [R15]
        s_nxt.disp_ms       = 13'h0000;
        s_nxt.upper         = s_r.upper_sel ? s_r.rate : s_r.total; // [R17]
        s_nxt.lower         = !s_r.lower_en ? 32'h0000_0000 : (s_r.upper_sel ? s_r.total : s_r.rate); // [R18]
        s_nxt.upper_is_rate = s_r.upper_sel;
        s_nxt.lower_on      = s_r.lower_en; // [R18]
      end else begin
        s_nxt.disp_ms = s_r.disp_ms + 13'h0001;
      end
    end

    // The pulse output permission tracks the mode directly, not the display refresh.
    s_nxt.pout_ok = (s_r.mode != dpc_pkg::MODE_DIFF); // [R14] [R16]

    // Writes take effect at the edge where the master sees waitrequest low.
    if (avs_write && !s_r.wreq) begin
      unique case (avs_address)
        `DPC_OFF_INPUT_CFG: begin
          s_nxt.kind_a = wr_val[`DPC_F_KIND_A +: 3];
          s_nxt.kind_b = wr_val[`DPC_F_KIND_B +: 3]; // [R1]
          s_nxt.deb_a  = wr_val[`DPC_F_DEB_A +: 2];
          s_nxt.deb_b  = wr_val[`DPC_F_DEB_B +: 2]; // [R3]
          s_nxt.edge_a = wr_val[`DPC_F_EDGE_A];
          s_nxt.edge_b = wr_val[`DPC_F_EDGE_B];
          s_nxt.mode   = dpc_pkg::dpc_mode_t'(wr_val[`DPC_F_MODE +: 2]); // [R8]
        end
        `DPC_OFF_DISP_CFG: begin
          s_nxt.interval  = wr_val[`DPC_F_INTERVAL +: 3];
          s_nxt.upper_sel = wr_val[`DPC_F_UPPER_SEL];
          s_nxt.lower_en  = wr_val[`DPC_F_LOWER_EN];
        end
        `DPC_OFF_CTRL: begin
          // A pulse counted in the clearing cycle is kept rather than lost.
          if (avs_byteenable[0] && avs_writedata[0]) begin
            s_nxt.total = delta;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // State register with synchronous reset.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s_r          <= '0;
      s_r.wreq     <= 1'b1;
      s_r.interval <= `DPC_RST_INTERVAL;
      s_r.lower_en <= `DPC_RST_LOWER_EN;
      s_r.pout_ok  <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign avs_readdata       = s_r.rdata;
  assign avs_waitrequest    = s_r.wreq;
  assign disp_upper_value   = s_r.upper;
  assign disp_upper_is_rate = s_r.upper_is_rate;
  assign disp_lower_value   = s_r.lower;
  assign disp_lower_on      = s_r.lower_on;
  assign pulse_out_avail    = s_r.pout_ok;

endmodule

/* bench/dpc_sensor_model.sv */
// Behavioural pulse sensor that turns a requested signal level into the two comparator lines.
`timescale 1ns/10ps
module dpc_sensor_model (
  input  wire logic       clk_sys,
  input  wire logic [1:0] lvl,
  output logic            above_high,
  output logic            below_low
);
  // Level 2 is above the high threshold, 0 below the low one, 1 between them.
  // Both lines are never high together, as on a real signal.
  always_ff @(posedge clk_sys) begin
    above_high <= (lvl == 2'h2);
    below_low  <= (lvl == 2'h0);
  end
endmodule

/* bench/dpc_top_assertions.sv */
// Concurrent checks on the ports of the pulse counter front end.
`timescale 1ns/10ps
module dpc_top_assertions #(
  parameter int unsigned US_CYC = 50
) (
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic [4:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        in_a_above_high,
  input wire logic        in_a_below_low,
  input wire logic        in_b_above_high,
  input wire logic        in_b_below_low,
  input wire logic [31:0] disp_upper_value,
  input wire logic        disp_upper_is_rate,
  input wire logic [31:0] disp_lower_value,
  input wire logic        disp_lower_on,
  input wire logic        pulse_out_avail
);
  localparam int unsigned MIN_GAP = 500 * 1000 * US_CYC;
  logic [31:0] gap_r;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // Cycles since the upper display last moved; the shortest refresh interval bounds it from below.
  always_ff @(posedge clk_sys) begin
    if (!rst_n || $changed(disp_upper_value)) begin
      gap_r <= 32'h0;
    end else begin
      gap_r <= gap_r + 32'h1;
    end
  end

  AST_WAIT_ANSWER: assert property ((avs_read || avs_write) && avs_waitrequest |=>
    !avs_waitrequest ##1 avs_waitrequest) else $error("access not answered in one cycle");
  AST_WAIT_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  AST_IDLE_WAIT: assert property (!avs_read && !avs_write |=> avs_waitrequest)
    else $error("answer without request");
  AST_RD_STABLE: assert property (!(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
    else $error("read data moved without a read");
  AST_RST_STATE: assert property ($rose(rst_n) |-> avs_waitrequest && avs_readdata == 32'h0
    && !disp_lower_on && !disp_upper_is_rate && pulse_out_avail) else $error("bad state after reset");
  AST_LOWER_OFF: assert property (!disp_lower_on |-> disp_lower_value == 32'h0)
    else $error("lower value shown while lower display off");
  AST_POUT_CFG: assert property ($changed(pulse_out_avail) |-> $past(avs_write, 1)
    || $past(avs_write, 2) || $past(avs_write, 3)) else $error("pulse output availability moved alone");
  AST_DISP_HOLD: assert property ($changed(disp_upper_value) |-> gap_r + 32'h4 >= MIN_GAP)
    else $error("display refreshed too early");

  // Main scenarios seen at the ports.
  cover property (avs_read && !avs_waitrequest);
  cover property (avs_write && !avs_waitrequest);
  cover property ($fell(pulse_out_avail));
endmodule

bind dpc_top dpc_top_assertions #(.US_CYC(US_CYC)) u_chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .in_a_above_high(in_a_above_high),
  .in_a_below_low(in_a_below_low), .in_b_above_high(in_b_above_high), .in_b_below_low(in_b_below_low),
  .disp_upper_value(disp_upper_value), .disp_upper_is_rate(disp_upper_is_rate),
  .disp_lower_value(disp_lower_value), .disp_lower_on(disp_lower_on), .pulse_out_avail(pulse_out_avail));

/* bench/tb_top.sv */
// Self-checking bench of the pulse counter front end.
`timescale 1ns/10ps
`include "dpc_defs.svh"
module tb_top;
  localparam int unsigned USC = 2;  // One microsecond is two cycles, so all times shrink 25 times.
  localparam int H = 30;            // Phase length, well above the light debounce of other kinds.
  localparam logic [1:0] HI = 2'h2;
  localparam logic [1:0] MD = 2'h1;
  localparam logic [1:0] LO = 2'h0;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic [4:0]  adr = 5'h00;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdat;
  logic [1:0]  lva = 2'h0;
  logic [1:0]  lvb = 2'h0;
  logic        wq, ah, al, bh, bl, uir, lon, pav;
  logic [31:0] rq, uv, lv;
  int          errors = 0;
  int          total_checks = 0;

  dpc_top #(.US_CYC(USC)) DUT (
    .clk_sys(clk_sys), .rst_n(rst_n), .avs_address(adr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wd), .avs_byteenable(4'hF), .avs_readdata(rq), .avs_waitrequest(wq),
    .in_a_above_high(ah), .in_a_below_low(al), .in_b_above_high(bh), .in_b_below_low(bl),
    .disp_upper_value(uv), .disp_upper_is_rate(uir), .disp_lower_value(lv), .disp_lower_on(lon),
    .pulse_out_avail(pav));
  dpc_sensor_model u_sen_a (.clk_sys(clk_sys), .lvl(lva), .above_high(ah), .below_low(al));
  dpc_sensor_model u_sen_b (.clk_sys(clk_sys), .lvl(lvb), .above_high(bh), .below_low(bl));

  // Clock at 50 MHz.
  initial begin
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  // One access; the request stands until waitrequest is seen low, then an idle edge follows.
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    rd <= ~w;
    wr <= w;
    adr <= a;
    wd <= d;
    do begin
      @(posedge clk_sys);
    end while (wq !== 1'b0);
    rdat = rq;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic rt();
    bus(1'b0, `DPC_OFF_TOTAL, 32'h0);
  endtask

  // Sets mode, edges, debounce and kind of input B, then clears the total.
  task automatic cfg(input logic [1:0] m, input logic ea, input logic eb, input logic [1:0] da,
                     input logic [1:0] db, input logic [2:0] kb);
    bus(1'b1, `DPC_OFF_INPUT_CFG, {18'h0, m, eb, ea, db, da, kb, 3'h0});
    bus(1'b1, `DPC_OFF_CTRL, 32'h1);
  endtask

  task automatic ph(input logic [1:0] a, input logic [1:0] b, input int n);
    lva <= a;
    lvb <= b;
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic t_reset();
    chk({28'h0, uir, lon, pav, 1'b0}, 32'h2);
    bus(1'b0, `DPC_OFF_INPUT_CFG, 32'h0);
    chk(rdat, 32'h0);
    bus(1'b0, `DPC_OFF_DISP_CFG, 32'h0);
    chk(rdat, 32'h11);
    bus(1'b1, `DPC_OFF_TOTAL, 32'h5A);
    rt();
    chk(rdat, 32'h0);
  endtask

  // Every sensor kind and every refresh interval code, with rate shown on top.
  task automatic t_cfg();
    for (int k = 0; k < 6; k++) begin
      bus(1'b1, `DPC_OFF_INPUT_CFG, 32'(k) << 3);
      bus(1'b0, `DPC_OFF_INPUT_CFG, 32'h0);
      chk(rdat, 32'(k) << 3);
      bus(1'b1, `DPC_OFF_DISP_CFG, 32'(k) | 32'h18);
      bus(1'b0, `DPC_OFF_DISP_CFG, 32'h0);
      chk(rdat, 32'(k) | 32'h18);
    end
    bus(1'b1, `DPC_OFF_DISP_CFG, 32'h11);
  endtask

  task automatic t_sum();
    cfg(2'h0, 1'b0, 1'b0, 2'h2, 2'h2, 3'h0);
    ph(HI, LO, H);
    ph(LO, LO, H);
    ph(LO, HI, H);
    ph(LO, LO, H);
    ph(HI, HI, H);
    ph(LO, LO, H);
    rt();
    chk(rdat, 32'h4);
    cfg(2'h0, 1'b1, 1'b0, 2'h2, 2'h2, 3'h0);
    ph(HI, LO, H);
    rt();
    chk(rdat, 32'h0);
    ph(LO, LO, H);
    rt();
    chk(rdat, 32'h1);
  endtask

  task automatic t_diff();
    cfg(2'h1, 1'b0, 1'b1, 2'h2, 2'h2, 3'h0);
    chk({31'h0, pav}, 32'h0);
    repeat (2) begin
      ph(HI, LO, H);
      ph(LO, LO, H);
    end
    ph(LO, HI, H);
    rt();
    chk(rdat, 32'h2);
    ph(LO, LO, H);
    repeat (2) begin
      ph(LO, HI, H);
      ph(LO, LO, H);
    end
    rt();
    chk(rdat, 32'hFFFFFFFF);
  endtask

  task automatic t_dir();
    cfg(2'h2, 1'b0, 1'b1, 2'h2, 2'h2, 3'h0);
    ph(HI, LO, H);
    ph(LO, LO, H);
    ph(LO, HI, H);
    repeat (2) begin
      ph(HI, HI, H);
      ph(LO, HI, H);
    end
    rt();
    chk(rdat, 32'hFFFFFFFF);
    ph(LO, LO, H);
    rt();
    chk(rdat, 32'hFFFFFFFF);
  endtask

  // Equal mark and space but uneven spacing of the A and B edges; a falling edge of A while B is low would spoil the count.
  task automatic t_quad();
    cfg(2'h3, 1'b1, 1'b1, 2'h2, 2'h2, 3'h0);
    repeat (2) begin
      ph(LO, HI, H);
      ph(HI, HI, 3 * H);
      ph(HI, LO, H);
      ph(LO, LO, 3 * H);
    end
    rt();
    chk(rdat, 32'h2);
    ph(HI, LO, H);
    ph(HI, HI, H);
    ph(LO, HI, H);
    ph(LO, LO, H);
    rt();
    chk(rdat, 32'h1);
  endtask

  // Input A at default debounce of other kinds, input B a contact at light debounce.
  task automatic t_deb();
    cfg(2'h0, 1'b0, 1'b0, 2'h0, 2'h2, 3'h5);
    ph(HI, LO, 50);
    ph(LO, LO, 200);
    rt();
    chk(rdat, 32'h0);
    ph(HI, LO, 200);
    ph(MD, LO, 200);
    ph(HI, LO, 200);
    ph(LO, LO, 200);
    rt();
    chk(rdat, 32'h1);
    ph(LO, HI, 600);
    ph(LO, LO, 900);
    rt();
    chk(rdat, 32'h1);
    ph(LO, HI, 900);
    ph(LO, LO, 900);
    rt();
    chk(rdat, 32'h2);
  endtask

  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Main sequence after six cycles of reset.
  initial begin
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    t_reset();
    t_cfg();
    t_sum();
    t_diff();
    t_dir();
    t_quad();
    t_deb();
    tally_and_finish();
  end

  // A hang counts as a mismatch; the whole run needs well under this many cycles.
  initial begin
    int c;
    c = 0;
    while (c < 40000) begin
      @(posedge clk_sys);
      c++;
    end
    errors++;
    tally_and_finish();
  end
endmodule
